// ==== core/ddc_decimation_nco_select.sv ====
// Downconverter path: decimation chain select, source select, profile select.
`timescale 1ns/1ps
`default_nettype none

module ddc_decimation_nco_select (
  input  wire logic                       clock,         // Sample clock.
  input  wire logic                       rst_n,         // Sync reset.
  input  wire ddc_pkg::ddc_bus_t          bus,           // Register access.
  output var  logic [ddc_pkg::DATA_W-1:0] rdata,         // Read data.
  input  wire ddc_pkg::ddc_in_t           samples,       // Channel A/B.
  input  wire logic                       side_a_pin_zero, // Pin A0.
  input  wire logic                       side_a_pin_one,  // Pin A1.
  input  wire logic                       side_b_pin_zero, // Pin B0.
  input  wire logic                       side_b_pin_one,  // Pin B1.
  output var  ddc_pkg::ddc_out_t          out_stream,    // To framer.
  output var  ddc_pkg::ddc_chain_t        chain,         // Active chain.
  output var  logic [3:0]                 profile_index  // Active profile.
);
  import ddc_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [7:0]        path_control;
    logic [7:0]        input_ext;
    logic [7:0]        osc_profile;
    logic [7:0]        rdata;
    logic [3:0]        pin_s1;
    logic [3:0]        pin_s2;
    logic [3:0]        pin_s3;
    logic [3:0]        edge_count;
    logic [3:0]        profile;
    logic [1:0]        mix_phase;
    logic [RATIO_W-1:0] dec_count;
    logic [ACC_W-1:0]  acc_i;
    logic [ACC_W-1:0]  acc_q;
    ddc_chain_t        chain;
    ddc_out_t          out;
  } ddc_state_t;

  ddc_state_t s;
  ddc_state_t next_s;

  // ==========================================================================
  // Filter chain table: stage mask, complex ratio, real supported, legal.
  function automatic ddc_chain_t chain_lookup(input logic [2:0] dec,
                                              input logic [3:0] ext,
                                              input logic       c2r);
    logic [STG_N-1:0]   st;
    logic [RATIO_W-1:0] full;
    logic               real_ok;
    logic               legal;
    ddc_chain_t         r;
    st      = '0;
    full    = 6'h01;
    real_ok = 1'b1;
    legal   = 1'b1;
    case (dec)
      3'h0: begin
        st   = 7'h03;
        full = 6'h04;
      end
      3'h1: begin
        st   = 7'h07;
        full = 6'h08;
      end
      3'h2: begin
        st   = 7'h0f;
        full = 6'h10;
      end
      3'h3: begin
        st   = 7'h01;
        full = 6'h02;
      end
      3'h4: begin
        st   = 7'h21;
        full = 6'h06;
      end
      3'h5: begin
        st   = 7'h23;
        full = 6'h0c;
      end
      3'h6: begin
        st   = 7'h27;
        full = 6'h18;
      end
      default: begin
        case (ext)
          4'h0: begin
            st   = 7'h2f;
            full = 6'h30;
          end
          4'h2: begin
            st   = 7'h41;
            full = 6'h0a;
          end
          4'h3: begin
            st   = 7'h43;
            full = 6'h14;
          end
          4'h4: begin
            st   = 7'h47;
            full = 6'h28;
          end
          4'h7: begin
            st      = 7'h10;
            full    = 6'h03;
            real_ok = 1'b0;
          end
          4'h8: begin
            st      = 7'h50;
            full    = 6'h0f;
            real_ok = 1'b0;
          end
          4'h9: begin
            st      = 7'h52;
            full    = 6'h1e;
            real_ok = 1'b0;
          end
          default: begin
            legal = 1'b0;
          end
        endcase
      end
    endcase
    r.stages = st;
    r.unsup  = !legal || (c2r && !real_ok);
    // Real output halves the ratio since only I leaves the path.
    r.ratio  = (c2r && real_ok) ? (full >> 1) : full;
    return r;
  endfunction

  // Gain normalisation: shift by floor of log2 of the ratio.
  function automatic logic [2:0] norm_shift(input logic [RATIO_W-1:0] n);
    logic [2:0] k;
    k = 3'h0;
    for (int b = 1; b < RATIO_W; b++) begin
      if (n[b]) begin
        k = 3'(b);
      end
    end
    return k;
  endfunction

  // ==========================================================================
  // Next state.
  always_comb begin
    logic [3:0]        pins;
    logic [3:0]        rise;
    logic [3:0]        mode;
    logic [3:0]        limit;
    logic              c2r;
    logic [ACC_W-1:0]  src_i;
    logic [ACC_W-1:0]  src_q;
    logic [ACC_W-1:0]  mix_i;
    logic [ACC_W-1:0]  sum_i;
    logic [ACC_W-1:0]  sum_q;
    ddc_chain_t        cfg;
    logic [2:0]        sh;
    rise   = 4'h0;
    src_i  = '0;
    src_q  = '0;
    mix_i  = '0;
    sum_i  = '0;
    sum_q  = '0;
    cfg    = '0;
    sh     = 3'h0;
    next_s = s;
    pins   = {side_b_pin_one, side_b_pin_zero,
              side_a_pin_one, side_a_pin_zero};
    mode   = s.osc_profile[OSC_MODE_LSB +: 4];
    limit  = s.osc_profile[OSC_MAN_LSB +: 4];
    c2r    = s.path_control[CTL_C2R_BIT];

    // Register writes; reserved bits of the input select stay zero.
    next_s.rdata = 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        OFS_PATH_CONTROL: next_s.path_control = bus.wdata;
        OFS_INPUT_EXT:    next_s.input_ext = bus.wdata & INPUT_EXT_WMASK;
        OFS_OSC_PROFILE:  next_s.osc_profile = bus.wdata;
        default:          next_s.rdata = 8'h00;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        OFS_PATH_CONTROL: next_s.rdata = s.path_control;
        OFS_INPUT_EXT:    next_s.rdata = s.input_ext;
        OFS_OSC_PROFILE:  next_s.rdata = s.osc_profile;
        OFS_PATH_STATUS:  next_s.rdata = {2'b00, c2r, s.chain.unsup,
                                          s.profile};
        default:          next_s.rdata = 8'h00;
      endcase
    end

    // Pin synchronisers; edges are taken from the second and third stage.
    next_s.pin_s1 = pins;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    rise = s.pin_s2 & ~s.pin_s3;

    // Edge counter and profile select.
    if (mode >= MODE_EDGE_LO && mode <= MODE_EDGE_HI &&
        rise[mode[1:0]]) begin
      next_s.edge_count = (s.edge_count >= limit) ? 4'h0
                                                  : s.edge_count + 4'h1;
    end
    case (mode)
      MODE_MANUAL: next_s.profile = limit;
      4'h1: next_s.profile = {2'b00, s.pin_s2[2], s.pin_s2[0]};
      4'h2: next_s.profile = {2'b00, s.pin_s2[3], s.pin_s2[1]};
      4'h3: next_s.profile = {2'b00, s.pin_s2[1], s.pin_s2[0]};
      4'h4: next_s.profile = {2'b00, s.pin_s2[3], s.pin_s2[2]};
      4'h5: next_s.profile = {s.pin_s2[3], s.pin_s2[1],
                              s.pin_s2[2], s.pin_s2[0]};
      4'h6: next_s.profile = s.pin_s2;
      4'h8, 4'h9, 4'ha, 4'hb: next_s.profile = s.edge_count;
      default: next_s.profile = limit;
    endcase

    // Chain selection; a change restarts the decimation phase.
    cfg = chain_lookup(s.path_control[CTL_DEC_LSB +: 3],
                       s.input_ext[SEL_EXT_LSB +: 4], c2r);
    next_s.chain = cfg;

    // Source select per stream.
    src_i = ACC_W'(s.input_ext[SEL_I_BIT] ? samples.chan_b
                                          : samples.chan_a);
    src_q = ACC_W'(s.input_ext[SEL_Q_BIT] ? samples.chan_b
                                          : samples.chan_a);
    src_i = {{GROW_W{src_i[SAMPLE_W-1]}}, src_i[SAMPLE_W-1:0]};
    src_q = {{GROW_W{src_q[SAMPLE_W-1]}}, src_q[SAMPLE_W-1:0]};

    // Quarter-rate mix to real: I, -Q, -I, Q.
    case (s.mix_phase)
      2'h0:    mix_i = src_i;
      2'h1:    mix_i = ACC_W'(-src_q);
      2'h2:    mix_i = ACC_W'(-src_i);
      default: mix_i = src_q;
    endcase
    next_s.mix_phase = c2r ? s.mix_phase + 2'h1 : 2'h0;

    sum_i = s.acc_i + (c2r ? mix_i : src_i);
    sum_q = c2r ? '0 : s.acc_q + src_q;
    sh    = norm_shift(s.chain.ratio);
    next_s.out.valid = 1'b0;
    if (cfg != s.chain || s.chain.unsup) begin
      next_s.dec_count = '0;
      next_s.acc_i     = '0;
      next_s.acc_q     = '0;
    end else if (s.dec_count >= s.chain.ratio - 6'h01) begin
      next_s.dec_count     = '0;
      next_s.acc_i         = '0;
      next_s.acc_q         = '0;
      next_s.out.valid     = 1'b1;
      next_s.out.real_only = c2r;
      next_s.out.i = SAMPLE_W'($signed(sum_i) >>> sh);
      next_s.out.q = c2r ? '0 : SAMPLE_W'($signed(sum_q) >>> sh);
    end else begin
      next_s.dec_count = s.dec_count + 6'h01;
      next_s.acc_i     = sum_i;
      next_s.acc_q     = sum_q;
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s              <= '0;
      s.path_control <= RST_PATH_CONTROL;
      s.input_ext    <= RST_INPUT_EXT;
      s.osc_profile  <= RST_OSC_PROFILE;
      s.chain.stages <= 7'h03;
      s.chain.ratio  <= 6'h04;
    end else begin
      s <= next_s;
    end
  end

  assign rdata         = s.rdata;
  assign out_stream    = s.out;
  assign chain         = s.chain;
  assign profile_index = s.profile;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_real_only;
    s.out.valid && s.out.real_only |-> s.out.q == '0;
  endproperty
  a_real_only: assert property (p_real_only)
    else $error("real output carries Q data");

  property p_code000;
    s.path_control[2:0] == 3'h0 && !s.path_control[CTL_C2R_BIT]
      |=> s.chain.ratio == 6'h04 && s.chain.stages == 7'h03;
  endproperty
  a_code000: assert property (p_code000)
    else $error("code 000 complex ratio wrong");

  property p_code010;
    s.path_control[2:0] == 3'h2 && !s.path_control[CTL_C2R_BIT]
      |=> s.chain.ratio == 6'h10 && s.chain.stages == 7'h0f;
  endproperty
  a_code010: assert property (p_code010)
    else $error("code 010 complex ratio wrong");

  property p_code100_real;
    s.path_control[2:0] == 3'h4 && s.path_control[CTL_C2R_BIT]
      |=> s.chain.ratio == 6'h03 && s.chain.stages == 7'h21;
  endproperty
  a_code100_real: assert property (p_code100_real)
    else $error("code 100 real ratio wrong");

  property p_ext_ignored;
    s.path_control[2:0] != DEC_EXTENDED && $stable(s.path_control)
      && $changed(s.input_ext) |=> $stable(s.chain);
  endproperty
  a_ext_ignored: assert property (p_ext_ignored)
    else $error("extended field acted outside code 111");

  property p_ext0;
    s.path_control[2:0] == DEC_EXTENDED && s.input_ext[7:4] == 4'h0
      && !s.path_control[CTL_C2R_BIT] |=> s.chain.ratio == 6'h30;
  endproperty
  a_ext0: assert property (p_ext0)
    else $error("extended 0 ratio wrong");

  property p_ext2_real;
    s.path_control[2:0] == DEC_EXTENDED && s.input_ext[7:4] == 4'h2
      && s.path_control[CTL_C2R_BIT] |=> s.chain.ratio == 6'h05
      && s.chain.stages == 7'h41 && !s.chain.unsup;
  endproperty
  a_ext2_real: assert property (p_ext2_real)
    else $error("extended 2 real ratio wrong");

  property p_ext7_real;
    s.path_control[2:0] == DEC_EXTENDED && s.input_ext[7:4] == 4'h7
      && s.path_control[CTL_C2R_BIT] |=> s.chain.unsup ##1 !s.out.valid;
  endproperty
  a_ext7_real: assert property (p_ext7_real)
    else $error("unsupported real rate not flagged");

  property p_manual;
    s.osc_profile[7:4] == MODE_MANUAL
      |=> s.profile == $past(s.osc_profile[3:0]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual profile not followed");

  property p_wrap;
    s.osc_profile[7:4] == 4'h8 && s.pin_s2[0] && !s.pin_s3[0]
      && s.edge_count == s.osc_profile[3:0] |=> s.edge_count == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("edge counter failed to wrap");

  property p_advance;
    s.osc_profile[7:4] == 4'h8 && s.pin_s2[0] && !s.pin_s3[0]
      && s.edge_count < s.osc_profile[3:0]
      |=> s.edge_count == $past(s.edge_count) + 4'h1 ##1
          s.profile == $past(s.edge_count);
  endproperty
  a_advance: assert property (p_advance)
    else $error("edge counter failed to advance");

  property p_pin_mode1;
    s.osc_profile[7:4] == 4'h1
      |=> s.profile == {2'b00, $past(s.pin_s2[2]), $past(s.pin_s2[0])};
  endproperty
  a_pin_mode1: assert property (p_pin_mode1)
    else $error("pin mode 1 index wrong");

  c_complex_out: cover property (s.out.valid && !s.out.real_only);
  c_real_out:    cover property (s.out.valid && s.out.real_only);
  c_edge_wrap:   cover property (s.edge_count != 4'h0 ##1
                                 s.edge_count == 4'h0);
  c_ext_chain:   cover property (s.chain.stages[STG_FB] && s.out.valid);

endmodule // ddc_decimation_nco_select

`default_nettype wire

// ==== core/ddc_pkg.sv ====
// Constants, carrier types and register map of the downconverter path control.
//
// How it works
// - Real mode outputs I only via quarter-rate mix.
// - Code 000: first two half-bands, 2 or 4.
// - Code 001: three half-bands, 4 or 8.
// - Code 010: four half-bands, 8 or 16.
// - Code 011: first half-band only, 1 or 2.
// - Code 100: half-band plus third-band, 3 or 6.
// - Code 101: two half-bands, third-band, 6 or 12.
// - Code 110: three half-bands, third-band, 12 or 24.
// - Code 111 defers to extended upper nibble field.
// - Extended field ignored unless primary code is 111.
// - Extended 0: third-band plus four half-bands, 48/24.
// - Extended 2: fifth-band plus half-band, 10/5.
// - Extended 3: fifth-band plus two half-bands, 20/10.
// - Extended 4: fifth-band plus three half-bands, 40/20.
// - Extended 7: first third-band, 3; no real.
// - Extended 8: fifth-band with third-band, 15; no real.
// - Extended 9: half-band, fifth, third-band, 30; no real.
// - Profile mode 0 uses the manual nibble.
// - Edge counter wraps to zero on the edge after it reaches the programmed nibble.
// - Edge counter advances on chosen pin rising edge.
// - Complex mode delivers both I and Q streams.
// - Manual nibble selects one of sixteen profiles.

`default_nettype none

package ddc_pkg;

  // ==========================================================================
  // Register map.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] OFS_PATH_CONTROL = 12'h310;
  localparam logic [11:0] OFS_INPUT_EXT    = 12'h311;
  localparam logic [11:0] OFS_OSC_PROFILE  = 12'h314;
  localparam logic [11:0] OFS_PATH_STATUS  = 12'h31f;
  localparam logic [7:0]  RST_PATH_CONTROL = 8'h00;
  localparam logic [7:0]  RST_INPUT_EXT    = 8'h00;
  localparam logic [7:0]  RST_OSC_PROFILE  = 8'h00;
  localparam logic [7:0]  INPUT_EXT_WMASK  = 8'hf5;

  // ==========================================================================
  // Field positions.
  localparam int CTL_C2R_BIT   = 3;
  localparam int CTL_DEC_LSB   = 0;
  localparam int SEL_I_BIT     = 0;
  localparam int SEL_Q_BIT     = 2;
  localparam int SEL_EXT_LSB   = 4;
  localparam int OSC_MAN_LSB   = 0;
  localparam int OSC_MODE_LSB  = 4;
  localparam int STA_PROF_LSB  = 0;
  localparam int STA_UNSUP_BIT = 4;
  localparam int STA_REAL_BIT  = 5;

  // Filter stage positions in the chain mask.
  localparam int STG_HB1 = 0;
  localparam int STG_HB2 = 1;
  localparam int STG_HB3 = 2;
  localparam int STG_HB4 = 3;
  localparam int STG_TB1 = 4;
  localparam int STG_TB2 = 5;
  localparam int STG_FB  = 6;
  localparam int STG_N   = 7;

  // ==========================================================================
  // Codes.
  localparam logic [2:0] DEC_EXTENDED  = 3'h7;
  localparam logic [3:0] MODE_MANUAL   = 4'h0;
  localparam logic [3:0] MODE_EDGE_LO  = 4'h8;
  localparam logic [3:0] MODE_EDGE_HI  = 4'hb;

  // ==========================================================================
  // Sample path sizes.
  localparam int SAMPLE_W = 16;
  localparam int GROW_W   = 6;
  localparam int ACC_W    = SAMPLE_W + GROW_W;
  localparam int RATIO_W  = 6;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ddc_bus_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] chan_a;
    logic signed [SAMPLE_W-1:0] chan_b;
  } ddc_in_t;

  typedef struct packed {
    logic                       valid;
    logic                       real_only;
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } ddc_out_t;

  typedef struct packed {
    logic [STG_N-1:0]   stages;
    logic [RATIO_W-1:0] ratio;
    logic               unsup;
  } ddc_chain_t;

endpackage

`default_nettype wire

// ==== sim/ddc_partner.sv ====
// Converter channel source and output framer model for the downconverter path.
`timescale 1ns/1ps
`default_nettype none

module ddc_partner (
  input  wire logic                              clock,      // Sample clock.
  input  wire logic signed [ddc_pkg::SAMPLE_W-1:0] level_a,  // Channel A level.
  input  wire logic signed [ddc_pkg::SAMPLE_W-1:0] level_b,  // Channel B level.
  output var  ddc_pkg::ddc_in_t                  samples,    // To the path.
  input  wire ddc_pkg::ddc_out_t                 out_stream, // From the path.
  output var  int                                words       // Words framed.
);
  import ddc_pkg::*;

  // ==========================================================================
  // Converters hand over one sample pair on every rising clock edge.
  initial samples = '0;
  initial words = 0;

  always @(posedge clock) begin
    samples.chan_a <= level_a;
    samples.chan_b <= level_b;
  end

  // ==========================================================================
  // The framer takes every word that is marked valid.
  always @(posedge clock) begin
    if (out_stream.valid === 1'b1) begin
      words <= words + 1;
    end
  end

endmodule // ddc_partner

`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the downconverter path control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ddc_pkg::*;

  typedef struct packed {
    logic                       r;
    logic signed [SAMPLE_W-1:0] a;
    logic signed [SAMPLE_W-1:0] b;
  } ddc_note_t;

  logic                       clock       = 1'b0;
  logic                       rst_n       = 1'b0;
  ddc_bus_t                   bus         = '0;
  logic [DATA_W-1:0]          rdata;
  ddc_in_t                    samples;
  logic [3:0]                 pins        = 4'h0;
  ddc_out_t                   out_stream;
  ddc_chain_t                 chain;
  logic [3:0]                 profile_index;
  logic signed [SAMPLE_W-1:0] lvl_a       = '0;
  logic signed [SAMPLE_W-1:0] lvl_b       = '0;
  int                         words;
  int                         miscompares = 0;
  int                         checks_done = 0;
  ddc_note_t                  notes[$];

  always #2 clock = ~clock;

  ddc_decimation_nco_select dut (
    .clock           (clock),
    .rst_n           (rst_n),
    .bus             (bus),
    .rdata           (rdata),
    .samples         (samples),
    .side_a_pin_zero (pins[0]),
    .side_a_pin_one  (pins[1]),
    .side_b_pin_zero (pins[2]),
    .side_b_pin_one  (pins[3]),
    .out_stream      (out_stream),
    .chain           (chain),
    .profile_index   (profile_index)
  );

  ddc_partner model (
    .clock      (clock),
    .level_a    (lvl_a),
    .level_b    (lvl_b),
    .samples    (samples),
    .out_stream (out_stream),
    .words      (words)
  );

  // ==========================================================================
  // Comparison, verdict and bounded waiting.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic drain();
    for (int t = 0; t < 200 && notes.size() > 0; t++) wait_cyc(1);
    if (notes.size() > 0) begin
      miscompares++;
      finish_test();
    end
  endtask

  // ==========================================================================
  // Register bus master.
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    check({24'h0, rdata}, {24'h0, e});
  endtask

  // ==========================================================================
  // Expected chain: codes 0..6 primary, 10 plus code for extended.
  function automatic logic [13:0] exp_chain(input int k, input logic c);
    logic [12:0] sf;
    logic        bad;
    bad = 1'b0;
    case (k)
      0:       sf = {7'h03, 6'd4};
      1:       sf = {7'h07, 6'd8};
      2:       sf = {7'h0f, 6'd16};
      3:       sf = {7'h01, 6'd2};
      4:       sf = {7'h21, 6'd6};
      5:       sf = {7'h23, 6'd12};
      6:       sf = {7'h27, 6'd24};
      10:      sf = {7'h2f, 6'd48};
      12:      sf = {7'h41, 6'd10};
      13:      sf = {7'h43, 6'd20};
      14:      sf = {7'h47, 6'd40};
      17:      sf = {7'h10, 6'd3};
      18:      sf = {7'h50, 6'd15};
      19:      sf = {7'h52, 6'd30};
      default: bad = 1'b1;
    endcase
    bad = bad || (c && k >= 17);
    return {sf[12:6], (c ? sf[5:0] >> 1 : sf[5:0]), bad};
  endfunction

  task automatic chk_chain(input int k, input logic c);
    logic [13:0] e;
    e = exp_chain(k, c);
    wait_cyc(3);
    if (e[0]) check({31'h0, chain.unsup}, 32'h1);
    else check({18'h0, chain}, {18'h0, e});
  endtask

  task automatic pulse(input int p);
    @(posedge clock);
    pins[p] <= 1'b1;
    wait_cyc(6);
    @(posedge clock);
    pins[p] <= 1'b0;
    wait_cyc(6);
  endtask

  // ==========================================================================
  // Output watcher: each valid word seen while a note is queued is matched with the oldest note.
  always @(posedge clock) begin
    ddc_note_t                  n;
    logic signed [SAMPLE_W-1:0] ei;
    logic signed [SAMPLE_W-1:0] i;
    if (rst_n === 1'b1 && out_stream.valid === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      i = out_stream.i;
      ei = n.a;
      if (n.r && (i === -n.b || i === -n.a || i === n.b)) ei = i;
      check({16'h0, i}, {16'h0, ei});
      check({15'h0, out_stream.real_only, out_stream.q},
            {15'h0, n.r, (n.r ? 16'h0 : n.b)});
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    int         w;
    int         ext_codes[8];
    logic [3:0] e;
    ext_codes = '{0, 2, 3, 4, 1, 7, 8, 9};
    void'($urandom(32'hdee05a0a));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    reg_rd(OFS_PATH_CONTROL, RST_PATH_CONTROL);
    reg_rd(OFS_INPUT_EXT, RST_INPUT_EXT);
    reg_rd(OFS_OSC_PROFILE, RST_OSC_PROFILE);
    reg_wr(OFS_INPUT_EXT, 8'hff);
    reg_rd(OFS_INPUT_EXT, 8'hf5);
    reg_wr(12'h312, 8'h5a);
    reg_rd(12'h312, 8'h00);
    reg_wr(OFS_PATH_CONTROL, 8'ha5);
    reg_rd(OFS_PATH_CONTROL, 8'ha5);
    reg_wr(OFS_INPUT_EXT, 8'h20);
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 7; k++) begin
        reg_wr(OFS_PATH_CONTROL, {4'h0, c[0], k[2:0]});
        chk_chain(k, c[0]);
      end
      for (int j = 0; j < 8; j++) begin
        reg_wr(OFS_PATH_CONTROL, {4'h0, c[0], DEC_EXTENDED});
        reg_wr(OFS_INPUT_EXT, {ext_codes[j][3:0], 4'h0});
        chk_chain(10 + ext_codes[j], c[0]);
      end
    end
    w = words;
    wait_cyc(40);
    check(32'(words - w), 32'h0);
    reg_wr(OFS_PATH_CONTROL, 8'h03);
    for (int s = 0; s < 4; s++) begin
      lvl_a <= 16'($urandom_range(16000)) - 16'sd8000;
      lvl_b <= 16'($urandom_range(16000)) - 16'sd8000;
      reg_wr(OFS_INPUT_EXT, {5'h0, s[1], 1'b0, s[0]});
      wait_cyc(8);
      repeat (3) notes.push_back({1'b0, (s[0] ? lvl_b : lvl_a),
                                  (s[1] ? lvl_b : lvl_a)});
      drain();
    end
    reg_wr(OFS_PATH_CONTROL, 8'h0b);
    reg_wr(OFS_INPUT_EXT, 8'h04);
    wait_cyc(8);
    repeat (4) notes.push_back({1'b1, lvl_a, lvl_b});
    drain();
    reg_wr(OFS_OSC_PROFILE, 8'h0f);
    wait_cyc(3);
    check({28'h0, profile_index}, 32'hf);
    reg_rd(OFS_PATH_STATUS, 8'h2f);
    for (int m = 1; m < 7; m++) begin
      reg_wr(OFS_OSC_PROFILE, {m[3:0], 4'h6});
      repeat (3) begin
        @(posedge clock);
        pins <= 4'($urandom);
        wait_cyc(5);
        case (m)
          1:       e = {2'b00, pins[2], pins[0]};
          2:       e = {2'b00, pins[3], pins[1]};
          3:       e = {2'b00, pins[1], pins[0]};
          4:       e = {2'b00, pins[3], pins[2]};
          5:       e = {pins[3], pins[1], pins[2], pins[0]};
          default: e = pins;
        endcase
        check({28'h0, profile_index}, {28'h0, e});
      end
    end
    @(posedge clock);
    pins <= 4'h0;
    for (int p = 0; p < 4; p++) begin
      reg_wr(OFS_OSC_PROFILE, {MODE_EDGE_LO | 4'(p), 4'h2});
      wait_cyc(4);
      for (int t = 0; t < 4 && profile_index !== 4'h0; t++) pulse(p);
      for (int n = 1; n < 4; n++) begin
        pulse(p);
        check({28'h0, profile_index}, 32'(n % 3));
      end
    end
    finish_test();
  end

endmodule // testbench

`default_nettype wire
